/* design/rx_link.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rx_link_defs.svh"
module rx_link #(
	parameter int LANES = 2,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Control and configuration
	input wire logic link_enable_i,
	input wire rx_link_pkg::cfg_t cfg_i,
	input wire logic sysref_i,
	// Link to and from the transmitter
	input wire rx_link_pkg::char_t [LANES-1:0] lane_char_i,
	output logic sync_n_o,
	// Status
	output logic link_up_o,
	output logic cfg_error_o,
	output logic sysref_request_o,
	// Aligned data
	output rx_link_pkg::lane_out_t [LANES-1:0] lane_o
);

	// ----------------------------------------------------------------
	// Configuration check and multiframe clock
	// ----------------------------------------------------------------
	logic [17:0] fk;
	logic cfg_ok;
	logic sysref_q, sysref_d, sysref_rise, sysref_seen_q, sysref_seen_d;
	logic [9:0] lmfc_q, lmfc_d;
	logic lmfc_edge;

	assign fk = 18'(cfg_i.f_octets) * 18'(cfg_i.k_frames);
	assign cfg_ok = (cfg_i.f_octets != 9'h000) && (cfg_i.k_frames != 9'h000)
		&& (fk >= `RX_FK_MIN) && (cfg_i.k_frames <= `RX_K_MAX) && (fk <= `RX_FK_MAX);
	assign cfg_error_o = !cfg_ok;
	assign sysref_rise = sysref_i && !sysref_q;
	assign lmfc_edge = sysref_rise || (lmfc_q == 10'h000);

	always_comb begin
		sysref_d = sysref_i;
		sysref_seen_d = sysref_seen_q || sysref_rise;
		lmfc_d = lmfc_q;
		if (sysref_rise) begin
			lmfc_d = (fk == 18'h00001) ? 10'h000 : 10'h001;
		end else if ({8'h00, lmfc_q} >= fk - 18'h00001) begin
			lmfc_d = 10'h000;
		end else begin
			lmfc_d = lmfc_q + 10'h001;
		end
	end

	// A continuous SYSREF at the multiframe rate lands on phase zero and changes nothing.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sysref_q <= 1'b0;
			sysref_seen_q <= 1'b0;
			lmfc_q <= 10'h000;
		end else begin
			sysref_q <= sysref_d;
			sysref_seen_q <= sysref_seen_d;
			lmfc_q <= lmfc_d;
		end
	end

	// ----------------------------------------------------------------
	// Per-lane alignment tracking
	// ----------------------------------------------------------------
	logic [2:0] cgs_q [LANES];
	logic [2:0] cgs_d [LANES];
	logic [2:0] ilas_q [LANES];
	logic [2:0] ilas_d [LANES];
	logic [8:0] oif_q [LANES];
	logic [8:0] oif_d [LANES];
	logic [8:0] fim_q [LANES];
	logic [8:0] fim_d [LANES];
	logic [1:0] miss_q [LANES];
	logic [1:0] miss_d [LANES];
	logic [7:0] last_q [LANES];
	logic [7:0] last_d [LANES];
	logic [7:0] wdata [LANES];
	logic [LANES-1:0] started_q, started_d, ovf_q, ovf_d;
	logic [LANES-1:0] start, wr_valid, wr_ready, cgs_done, lane_bad;
	logic [LANES-1:0] frame_end, mf_end, is_marker, placed;
	logic [8:0] cur_oif [LANES];
	logic [8:0] cur_fim [LANES];
	logic restart, release_all;

	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			cgs_d[i] = cgs_q[i];
			ilas_d[i] = ilas_q[i];
			oif_d[i] = oif_q[i];
			fim_d[i] = fim_q[i];
			miss_d[i] = miss_q[i];
			last_d[i] = last_q[i];
			started_d[i] = started_q[i];
			ovf_d[i] = ovf_q[i];
			cgs_done[i] = (cgs_q[i] == `RX_CGS_COUNT);
			start[i] = 1'b0;
			cur_oif[i] = started_q[i] ? oif_q[i] : 9'h000;
			cur_fim[i] = started_q[i] ? fim_q[i] : 9'h000;
			frame_end[i] = (cur_oif[i] == cfg_i.f_octets - 9'h001);
			mf_end[i] = frame_end[i] && (cur_fim[i] == cfg_i.k_frames - 9'h001);
			is_marker[i] = lane_char_i[i].k && (lane_char_i[i].octet == `RX_K28_7
				|| lane_char_i[i].octet == `RX_K28_3);
			placed[i] = (lane_char_i[i].octet == `RX_K28_7) ? frame_end[i] : mf_end[i];
			wdata[i] = lane_char_i[i].octet;
			if (restart) begin
				cgs_d[i] = 3'h0;
				ilas_d[i] = 3'h0;
				miss_d[i] = 2'h0;
				started_d[i] = 1'b0;
				ovf_d[i] = 1'b0;
			end else if (!started_q[i]) begin
				if (lane_char_i[i].k && lane_char_i[i].octet == `RX_K28_5) begin
					if (!cgs_done[i]) begin
						cgs_d[i] = cgs_q[i] + 3'h1;
					end
				end else if (!cgs_done[i]) begin
					cgs_d[i] = 3'h0;
				end else if (lane_char_i[i].k && lane_char_i[i].octet == `RX_K28_0
					&& sync_n_o) begin
					start[i] = 1'b1;
					started_d[i] = 1'b1;
				end
			end
			wr_valid[i] = !restart && (started_q[i] || start[i]);
			if (wr_valid[i]) begin
				if (ilas_q[i] == `RX_ILAS_MF && is_marker[i]) begin
					if (placed[i]) begin
						// marker restore; scrambled octets equal the character codes, unscrambled repeat the last octet
						if (cfg_i.scrambler_enable) begin
							wdata[i] = (lane_char_i[i].octet == `RX_K28_7) ?
								`RX_SCRAMBLED_F_OCTET : `RX_SCRAMBLED_A_OCTET;
						end else begin
							wdata[i] = last_q[i];
						end
					end else if (miss_q[i] != `RX_MISS_LIMIT) begin
						miss_d[i] = miss_q[i] + 2'h1;
					end
				end
				if (frame_end[i]) begin
					last_d[i] = wdata[i];
					oif_d[i] = 9'h000;
					fim_d[i] = mf_end[i] ? 9'h000 : cur_fim[i] + 9'h001;
				end else begin
					oif_d[i] = cur_oif[i] + 9'h001;
					fim_d[i] = cur_fim[i];
				end
				if (mf_end[i] && ilas_q[i] != `RX_ILAS_MF) begin
					ilas_d[i] = ilas_q[i] + 3'h1;
				end
				// The line cannot be stalled, so a full buffer means lane skew is too large.
				if (!wr_ready[i]) begin
					ovf_d[i] = 1'b1;
				end
			end
			lane_bad[i] = (miss_q[i] == `RX_MISS_LIMIT) || ovf_q[i];
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < LANES; i++) begin
				cgs_q[i] <= 3'h0;
				ilas_q[i] <= 3'h0;
				oif_q[i] <= 9'h000;
				fim_q[i] <= 9'h000;
				miss_q[i] <= 2'h0;
				last_q[i] <= 8'h00;
			end
			started_q <= '0;
			ovf_q <= '0;
		end else begin
			for (int i = 0; i < LANES; i++) begin
				cgs_q[i] <= cgs_d[i];
				ilas_q[i] <= ilas_d[i];
				oif_q[i] <= oif_d[i];
				fim_q[i] <= fim_d[i];
				miss_q[i] <= miss_d[i];
				last_q[i] <= last_d[i];
			end
			started_q <= started_d;
			ovf_q <= ovf_d;
		end
	end

	// ----------------------------------------------------------------
	// Elastic buffers
	// ----------------------------------------------------------------
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		elastic_buf #(
			.WIDTH(8),
			.DEPTH(DEPTH),
			.AW(AW)
		) u_buf (
			.clk_i(clk_i),
			.reset_n_i(reset_n_i),
			.clear_i(restart),
			.wr_valid_i(wr_valid[g]),
			.wr_data_i(wdata[g]),
			.wr_ready_o(wr_ready[g]),
			.rd_ready_i(release_all),
			.rd_valid_o(lane_o[g].valid),
			.rd_data_o(lane_o[g].octet)
		);
	end

	// ----------------------------------------------------------------
	// Link state machine
	// ----------------------------------------------------------------
	rx_link_pkg::link_state_t state_q, state_d;
	logic restart_q, restart_d, sync_n_q, sync_n_d, req_q, req_d;

	assign restart = (state_q == rx_link_pkg::ST_IDLE) || restart_q;
	assign release_all = (state_q == rx_link_pkg::ST_DATA);
	assign link_up_o = release_all;
	assign sync_n_o = sync_n_q;
	assign sysref_request_o = req_q;

	always_comb begin
		state_d = state_q;
		restart_d = 1'b0;
		sync_n_d = sync_n_q;
		req_d = 1'b0;
		unique case (state_q)
			rx_link_pkg::ST_IDLE: begin
				sync_n_d = 1'b1;
				if (link_enable_i && cfg_ok && sysref_seen_q) begin
					state_d = rx_link_pkg::ST_CGS;
					sync_n_d = 1'b0;
				end
			end
			rx_link_pkg::ST_CGS: begin
				// Comma counts are stale while a restart is still clearing them.
				if (&cgs_done && !restart_q) begin
					state_d = rx_link_pkg::ST_SYNC_WAIT;
				end
			end
			rx_link_pkg::ST_SYNC_WAIT: begin
				if (lmfc_edge) begin
					state_d = rx_link_pkg::ST_ILAS;
					sync_n_d = 1'b1;
				end
			end
			rx_link_pkg::ST_ILAS: begin
				if (&started_q) begin
					state_d = rx_link_pkg::ST_DATA;
				end
			end
			rx_link_pkg::ST_DATA: begin
			end
		endcase
		if (state_q != rx_link_pkg::ST_IDLE && state_q != rx_link_pkg::ST_CGS
			&& (|lane_bad)) begin
			state_d = rx_link_pkg::ST_CGS;
			restart_d = 1'b1;
			sync_n_d = 1'b0;
			req_d = 1'b1;
		end
		if (!link_enable_i || !cfg_ok) begin
			state_d = rx_link_pkg::ST_IDLE;
			sync_n_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= rx_link_pkg::ST_IDLE;
			restart_q <= 1'b0;
			sync_n_q <= 1'b1;
			req_q <= 1'b0;
		end else begin
			state_q <= state_d;
			restart_q <= restart_d;
			sync_n_q <= sync_n_d;
			req_q <= req_d;
		end
	end

endmodule // rx_link
`default_nettype wire

/* design/rx_link_defs.svh */
`ifndef RX_LINK_DEFS_SVH
`define RX_LINK_DEFS_SVH
// Notes on behaviour
// - K within ceil(17/F) to min(256, 1024/F).
// - Both ends reset multiframe clock on SYSREF.
// - Continuous SYSREF is multiframe rate or divided.
// - Receiver pulls sync low to request synchronization.
// - Four consecutive commas achieve code group sync.
// - Release sync at next multiframe edge afterwards.
// - Buffer from R; release all lanes together.
// - Unscrambled: placed F/A become previous last octet.
// - Scrambled: F restores 0xFC, A restores 0x7C.
// - Misplaced markers: error, resync, request SYSREF.

// ----------------------------------------------------------------
// Control characters as octets with the control flag set
// ----------------------------------------------------------------
`define RX_K28_5 8'hbc
`define RX_K28_0 8'h1c
`define RX_K28_3 8'h7c
`define RX_K28_7 8'hfc

// ----------------------------------------------------------------
// Restored octets for scrambled streams
// ----------------------------------------------------------------
`define RX_SCRAMBLED_F_OCTET 8'hfc
`define RX_SCRAMBLED_A_OCTET 8'h7c

// ----------------------------------------------------------------
// Counts and limits
// ----------------------------------------------------------------
`define RX_CGS_COUNT 3'h4
`define RX_ILAS_MF 3'h4
`define RX_FK_MIN 18'h00011
`define RX_K_MAX 9'h100
`define RX_FK_MAX 18'h00400
`define RX_MISS_LIMIT 2'h2

`endif

/* design/rx_link_pkg.sv */
`default_nettype none
package rx_link_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic k;
		logic [7:0] octet;
	} char_t;

	typedef struct packed {
		logic valid;
		logic [7:0] octet;
	} lane_out_t;

	typedef struct packed {
		logic [8:0] f_octets;
		logic [8:0] k_frames;
		logic scrambler_enable;
	} cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CGS,
		ST_SYNC_WAIT,
		ST_ILAS,
		ST_DATA
	} link_state_t;

endpackage
`default_nettype wire

/* design/elastic_buf.sv */
`timescale 1ns/1ns
`default_nettype none
module elastic_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic clear_i,
	// Write side
	input wire logic wr_valid_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	output logic wr_ready_o,
	// Read side
	input wire logic rd_ready_i,
	output logic rd_valid_o,
	output logic [WIDTH-1:0] rd_data_o
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q, wr_d, rd_q, rd_d, used;
	logic valid_q, valid_d;
	logic [WIDTH-1:0] data_q, data_d;
	logic do_wr;

	assign used = wr_q - rd_q;
	assign wr_ready_o = (used != (AW+1)'(DEPTH));
	assign do_wr = wr_valid_i && wr_ready_o;
	assign rd_valid_o = valid_q;
	assign rd_data_o = data_q;

	always_comb begin
		wr_d = wr_q;
		rd_d = rd_q;
		valid_d = 1'b0;
		data_d = data_q;
		if (clear_i) begin
			wr_d = '0;
			rd_d = '0;
		end else begin
			if (do_wr) begin
				wr_d = wr_q + (AW+1)'(1);
			end
			if (rd_ready_i && used != '0) begin
				rd_d = rd_q + (AW+1)'(1);
				valid_d = 1'b1;
				data_d = mem[rd_q[AW-1:0]];
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
			valid_q <= 1'b0;
			data_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			valid_q <= valid_d;
			data_q <= data_d;
		end
	end

	// The array has no reset; nothing reads a slot before it is written.
	always_ff @(posedge clk_i) begin
		if (do_wr && !clear_i) begin
			mem[wr_q[AW-1:0]] <= wr_data_i;
		end
	end

endmodule // elastic_buf
`default_nettype wire

/* bench/rx_link_chk.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rx_link_defs.svh"
module rx_link_chk #(
	parameter int LANES = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Watched ports
	input wire logic link_enable_i,
	input wire rx_link_pkg::cfg_t cfg_i,
	input wire logic sysref_i,
	input wire logic sync_n_o,
	input wire logic link_up_o,
	input wire logic cfg_error_o,
	input wire logic sysref_request_o,
	input wire rx_link_pkg::lane_out_t [LANES-1:0] lane_o
);
	logic [17:0] fk, ph, cnt_q, cnt_d;
	logic sr_q, seen_q, seen_d, legal, edge_now;
	logic [LANES-1:0] vld;
	// Local multiframe phase; a sysref rise makes the current cycle phase zero.
	always_comb begin
		fk = 18'(cfg_i.f_octets) * 18'(cfg_i.k_frames);
		legal = fk >= `RX_FK_MIN && cfg_i.k_frames <= `RX_K_MAX && fk <= `RX_FK_MAX;
		ph = (sysref_i && !sr_q) ? 18'h00000 : cnt_q;
		cnt_d = (ph + 18'h00001 >= fk) ? 18'h00000 : ph + 18'h00001;
		seen_d = seen_q || (sysref_i && !sr_q);
		edge_now = ph == 18'h00000;
		for (int i = 0; i < LANES; i++) vld[i] = lane_o[i].valid;
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_q <= 18'h00000;
			sr_q <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			sr_q <= sysref_i;
			seen_q <= seen_d;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_first_r;
		&vld && lane_o[0].octet == `RX_K28_0;
	endsequence
	sequence s_resync;
		!sysref_request_o && !sync_n_o && !link_up_o;
	endsequence
	a_cfg_legal_flag: assert property (cfg_error_o == !legal)
		else $error("cfg flag wrong");
	a_disable_idle: assert property (!link_enable_i [*2] |=> sync_n_o && !link_up_o)
		else $error("not idle when disabled");
	a_request_after_sysref: assert property ($fell(sync_n_o) |-> seen_q)
		else $error("sync low before sysref");
	a_release_on_edge: assert property ($rose(sync_n_o) && $past(link_enable_i) |-> $past(edge_now))
		else $error("sync release off edge");
	a_up_sync_high: assert property (link_up_o |-> sync_n_o)
		else $error("link up with sync low");
	a_lanes_together: assert property (|vld |-> &vld)
		else $error("lanes released apart");
	a_first_r_out: assert property ($rose(link_up_o) |=> s_first_r)
		else $error("first octet not start marker");
	a_resync_pulse: assert property (sysref_request_o |=> s_resync)
		else $error("bad resync request");
endmodule // rx_link_chk
bind rx_link rx_link_chk #(.LANES(LANES)) u_rx_link_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.link_enable_i(link_enable_i), .cfg_i(cfg_i), .sysref_i(sysref_i), .sync_n_o(sync_n_o),
	.link_up_o(link_up_o), .cfg_error_o(cfg_error_o), .sysref_request_o(sysref_request_o),
	.lane_o(lane_o));
`default_nettype wire

/* bench/tx_model.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rx_link_defs.svh"
module tx_model #(
	parameter int LANES = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Link control
	input wire logic sync_n_i,
	input wire logic sysref_i,
	input wire rx_link_pkg::cfg_t cfg_i,
	input wire logic inject_i,
	// Characters to the receiver
	output rx_link_pkg::char_t [LANES-1:0] lane_char_o
);
	// Restored octets the receiver should deliver, oldest first.
	logic [7:0] exp_q[$];
	logic [7:0] d, prev;
	logic sr_q, scrambled, fend;
	int ph, nxt, fk, f, st, mf;
	rx_link_pkg::char_t c;
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ph = 0;
			st = 0;
			sr_q = 1'b0;
			lane_char_o <= '0;
		end else begin
			f = int'(cfg_i.f_octets);
			fk = f * int'(cfg_i.k_frames);
			// Marker scheme follows the scrambler enable.
			scrambled = cfg_i.scrambler_enable;
			// Phase zero on sysref, period F times K.
			ph = (sysref_i && !sr_q) ? 0 : (ph + 1) % fk;
			sr_q = sysref_i;
			nxt = (ph + 1) % fk;
			fend = nxt % f == f - 1;
			c = {1'b1, `RX_K28_5};
			// Commas until the edge after release.
			if (!sync_n_i) begin
				st = 1;
				exp_q.delete();
			end else if (st == 1 && nxt == 0) begin
				st = 2;
				mf = 0;
			end
			if (st == 2) begin
				d = (mf == 1 && nxt == 1) ? cfg_i.k_frames[7:0] : 8'(nxt);
				c = {1'b0, d};
				if (nxt == 0) c = {1'b1, `RX_K28_0};
				if (nxt == fk - 1) c = {1'b1, `RX_K28_3};
				d = c.octet;
				if (nxt == fk - 1) mf++;
			end else if (st == 3) begin
				// Marker values are drawn often so that substitutions really occur.
				d = 8'($urandom);
				if (d[7]) d = d[6] ? 8'hfc : 8'h7c;
				c = {1'b0, d};
				if (fend && (scrambled ? d == 8'hfc : d == prev))
					c = {1'b1, (nxt == fk - 1 && !scrambled) ? `RX_K28_3 : `RX_K28_7};
				if (fend && scrambled && nxt == fk - 1 && d == 8'h7c)
					c = {1'b1, `RX_K28_3};
				if (!fend && inject_i)
					c = {1'b1, `RX_K28_3};
			end
			if (st >= 2) exp_q.push_back(d);
			if (st >= 2 && fend) prev = d;
			if (st == 2 && mf == 4) st = 3;
			lane_char_o <= {LANES{c}};
		end
	end
endmodule // tx_model
`default_nettype wire

/* bench/test_rx_link.sv */
`timescale 1ns/1ns
`default_nettype none
module test_rx_link;
	logic clk_i, reset_n_i, link_enable_i, sysref_i, inject, chk_en;
	logic sync_n, link_up, cfg_error, sysref_request;
	logic [7:0] want;
	rx_link_pkg::cfg_t cfg_i;
	rx_link_pkg::char_t [1:0] lane_char;
	rx_link_pkg::lane_out_t [1:0] lane_o;
	int err_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	int n;
	int f_tab[6] = '{1, 1, 4, 4, 8, 8};
	int k_tab[6] = '{17, 16, 256, 257, 128, 129};

	rx_link #(.LANES(2), .DEPTH(16), .AW(4)) u_rx_link (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.link_enable_i(link_enable_i), .cfg_i(cfg_i), .sysref_i(sysref_i), .lane_char_i(lane_char),
		.sync_n_o(sync_n), .link_up_o(link_up), .cfg_error_o(cfg_error),
		.sysref_request_o(sysref_request), .lane_o(lane_o));
	tx_model #(.LANES(2)) u_tx_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .sync_n_i(sync_n),
		.sysref_i(sysref_i), .cfg_i(cfg_i), .inject_i(inject), .lane_char_o(lane_char));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	function automatic logic legal(input int f, input int k);
		return f * k >= 17 && k <= 256 && f * k <= 1024;
	endfunction

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic wait_link();
		n = 0;
		while (link_up !== 1'b1 && n < 300) begin
			@(negedge clk_i);
			n++;
		end
		check("link up", 8'h01, 8'(link_up));
		chk_en = 1'b1;
	endtask

	task automatic bring_up(input logic scrambled);
		cfg_i = '{f_octets: 9'h002, k_frames: 9'h009, scrambler_enable: scrambled};
		sysref_i = 1'b1;
		@(negedge clk_i);
		sysref_i = 1'b0;
		link_enable_i = 1'b1;
		repeat (2) @(negedge clk_i);
		check("sync request", 8'h00, 8'(sync_n));
		wait_link();
	endtask

	// Every octet delivered while chk_en is set must match the restored stream of the transmitter.
	always @(negedge clk_i) begin
		if (chk_en && lane_o[0].valid === 1'b1) begin
			want = (u_tx_model.exp_q.size() > 0) ? u_tx_model.exp_q.pop_front() : 8'hxx;
			check("lane0 octet", want, lane_o[0].octet);
			check("lane1 octet", want, lane_o[1].octet);
		end
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			conclude();
		end
	end

	initial begin
		reset_n_i = 1'b0;
		link_enable_i = 1'b0;
		sysref_i = 1'b0;
		inject = 1'b0;
		chk_en = 1'b0;
		cfg_i = '{f_octets: 9'h002, k_frames: 9'h009, scrambler_enable: 1'b0};
		n = $urandom(87);
		repeat (20) @(negedge clk_i);
		reset_n_i = 1'b1;
		check("sync idle", 8'h01, 8'(sync_n));
		for (int i = 0; i < 12; i++) begin
			cfg_i.f_octets = 9'(i < 6 ? f_tab[i] : $urandom_range(1, 40));
			cfg_i.k_frames = 9'(i < 6 ? k_tab[i] : $urandom_range(1, 300));
			@(negedge clk_i);
			check("cfg error", 8'(!legal(cfg_i.f_octets, cfg_i.k_frames)), 8'(cfg_error));
		end
		bring_up(1'b0);
		repeat (200) @(negedge clk_i);
		chk_en = 1'b0;
		inject = 1'b1;
		n = 0;
		while (sysref_request !== 1'b1 && n < 100) begin
			@(negedge clk_i);
			n++;
		end
		check("sysref request", 8'h01, 8'(sysref_request));
		inject = 1'b0;
		wait_link();
		repeat (200) @(negedge clk_i);
		chk_en = 1'b0;
		link_enable_i = 1'b0;
		repeat (3) @(negedge clk_i);
		check("sync released", 8'h01, 8'(sync_n));
		check("link down", 8'h00, 8'(link_up));
		bring_up(1'b1);
		repeat (300) @(negedge clk_i);
		conclude();
	end
endmodule // test_rx_link
`default_nettype wire
